//--- dsr_receiver.sv
`timescale 1ns/1ns
module dsr_receiver #(
  parameter int PKT_MIN_CYC = dsr_pkg::PKT_MIN_CYC,
  parameter int PKT_MAX_CYC = dsr_pkg::PKT_MAX_CYC,
  parameter int PWM_PERIOD_CYC = dsr_pkg::PWM_PERIOD_CYC
) (
  input wire logic core_clk_i,
  input wire logic reset_i,
  input wire logic line_receive_input_i,
  input dsr_pkg::dsr_idx_t slot_addr_i,
  input dsr_pkg::dsr_idx_t slot_rd_idx_i,
  output dsr_pkg::dsr_slot_t slot_rd_data_o,
  output dsr_pkg::dsr_slot_t duty_o,
  output logic pkt_ok_o,
  output logic pwm_o
);
  import dsr_pkg::*;

  typedef enum logic [1:0] {ST_IDLE, ST_MARK, ST_DATA, ST_SKIP} dsr_state_t;

  localparam dsr_time_t BREAK_MIN_T = dsr_time_t'(BREAK_MIN_CYC);
  localparam dsr_time_t MARK_MIN_T = dsr_time_t'(MARK_MIN_CYC);
  localparam dsr_time_t PKT_MIN_T = dsr_time_t'(PKT_MIN_CYC);
  localparam dsr_time_t PKT_MAX_T = dsr_time_t'(PKT_MAX_CYC);
  localparam dsr_idx_t LAST_SLOT = dsr_idx_t'(SLOT_MAX);

  logic line_meta_reg;
  logic line_sync_reg;
  logic line_prev_reg;
  logic fall_edge;
  logic rise_edge;
  dsr_time_t now_reg;
  dsr_time_t fall_stamp_reg;
  dsr_time_t rise_stamp_reg;
  dsr_time_t low_len;
  dsr_time_t high_len;
  dsr_time_t b2b_cnt_reg;
  dsr_time_t b2b_snap_reg;
  logic armed_reg;
  logic brk_ok;
  logic stale;
  dsr_state_t state_reg;
  dsr_idx_t slot_idx_reg;
  dsr_slot_evt_t slot_evt;
  logic code_bad;
  logic wr_en;
  dsr_slot_t slot_mem [SLOT_COUNT];
  dsr_slot_t slot_rd_data_reg;
  logic pend_reg;
  dsr_slot_t sel_val_reg;
  dsr_slot_t duty_reg;
  logic pkt_ok_reg;
  logic b2b_in_window;

  // Two-stage synchroniser plus one delay stage for edge detection
  always_ff @(posedge core_clk_i) begin
    if (reset_i) begin
      line_meta_reg <= 1'b1;
      line_sync_reg <= 1'b1;
      line_prev_reg <= 1'b1;
    end else begin
      line_meta_reg <= line_receive_input_i;
      line_sync_reg <= line_meta_reg;
      line_prev_reg <= line_sync_reg;
    end
  end

  assign fall_edge = line_prev_reg & ~line_sync_reg;
  assign rise_edge = ~line_prev_reg & line_sync_reg;

  // Free-running time base with edge stamps; differences wrap safely
  always_ff @(posedge core_clk_i) begin
    if (reset_i) begin
      now_reg <= '0;
      fall_stamp_reg <= '0;
      rise_stamp_reg <= '0;
    end else begin
      now_reg <= now_reg + 1'b1;
      if (fall_edge) begin
        fall_stamp_reg <= now_reg;
      end
      if (rise_edge) begin
        rise_stamp_reg <= now_reg;
      end
    end
  end

  assign low_len = now_reg - fall_stamp_reg;
  assign high_len = now_reg - rise_stamp_reg;

  // Slot deserialiser
  dsr_slot_rx u_slot_rx (
    .core_clk_i(core_clk_i),
    .reset_i(reset_i),
    .line_i(line_sync_reg),
    .evt_o(slot_evt)
  );

  // Framing error arms the break check; the set wins over the clear
  always_ff @(posedge core_clk_i) begin
    if (reset_i) begin
      armed_reg <= 1'b0;
    end else if (slot_evt.frame_err) begin
      armed_reg <= 1'b1;
    end else if (rise_edge) begin
      armed_reg <= 1'b0;
    end
  end

  // Break accepted only if the low phase lasted long enough
  assign brk_ok = rise_edge && armed_reg && (low_len >= BREAK_MIN_T);

  // Break to break timer: restarts at each accepted break's falling edge
  always_ff @(posedge core_clk_i) begin
    if (reset_i) begin
      b2b_cnt_reg <= '1;
      b2b_snap_reg <= '1;
    end else begin
      if (brk_ok) begin
        b2b_cnt_reg <= low_len;
      end else if (b2b_cnt_reg != '1) begin
        b2b_cnt_reg <= b2b_cnt_reg + 1'b1;
      end
      if (fall_edge) begin
        b2b_snap_reg <= b2b_cnt_reg;
      end
    end
  end

  assign stale = (b2b_cnt_reg >= PKT_MAX_T);
  assign b2b_in_window = (b2b_snap_reg >= PKT_MIN_T) && (b2b_snap_reg <= PKT_MAX_T);
  assign code_bad = (slot_idx_reg == '0) && (slot_evt.data != NULL_START);

  // Storage only in a validated packet with a null start code
  assign wr_en = (state_reg == ST_DATA) && slot_evt.valid && !code_bad
    && (slot_idx_reg <= LAST_SLOT);

  // Packet sequencer
  always_ff @(posedge core_clk_i) begin
    if (reset_i) begin
      state_reg <= ST_IDLE;
    end else begin
      unique case (state_reg)
        ST_IDLE: begin
          if (brk_ok) begin
            state_reg <= ST_MARK;
          end
        end
        ST_MARK: begin
          if (stale) begin
            state_reg <= ST_IDLE;
          end else if (fall_edge) begin
            // Short mark after break: wait for the next good reset
            state_reg <= (high_len >= MARK_MIN_T) ? ST_DATA : ST_IDLE;
          end
        end
        ST_DATA: begin
          if (slot_evt.frame_err || stale) begin
            state_reg <= ST_IDLE;
          end else if (slot_evt.valid && code_bad) begin
            state_reg <= ST_SKIP;
          end else if (slot_evt.valid && slot_idx_reg == LAST_SLOT) begin
            state_reg <= ST_IDLE;
          end
        end
        ST_SKIP: begin
          if (slot_evt.frame_err || stale) begin
            state_reg <= ST_IDLE;
          end
        end
      endcase
    end
  end

  // Slot position counter, slot 0 being the start code
  always_ff @(posedge core_clk_i) begin
    if (reset_i) begin
      slot_idx_reg <= '0;
    end else if (state_reg == ST_MARK) begin
      slot_idx_reg <= '0;
    end else if (wr_en) begin
      slot_idx_reg <= slot_idx_reg + 1'b1;
    end
  end

  // Slot buffer, one flop entry per slot, written in arrival order
  for (genvar g = 0; g < SLOT_COUNT; g++) begin : g_slot
    always_ff @(posedge core_clk_i) begin
      if (reset_i) begin
        slot_mem[g] <= SLOT_RST;
      end else if (wr_en && slot_idx_reg == dsr_idx_t'(g)) begin
        slot_mem[g] <= slot_evt.data;
      end
    end
  end

  // Buffer read port; unmapped indices read zero
  always_ff @(posedge core_clk_i) begin
    if (reset_i) begin
      slot_rd_data_reg <= '0;
    end else if (slot_rd_idx_i <= LAST_SLOT) begin
      slot_rd_data_reg <= slot_mem[slot_rd_idx_i];
    end else begin
      slot_rd_data_reg <= '0;
    end
  end

  // Selected slot held until the packet proves complete
  always_ff @(posedge core_clk_i) begin
    if (reset_i) begin
      pend_reg <= 1'b0;
      sel_val_reg <= '0;
    end else if (brk_ok || stale) begin
      pend_reg <= 1'b0;
    end else if (wr_en && slot_idx_reg == slot_addr_i) begin
      pend_reg <= 1'b1;
      sel_val_reg <= slot_evt.data;
    end
  end

  // Duty follows the selection only at the next good break
  always_ff @(posedge core_clk_i) begin
    if (reset_i) begin
      duty_reg <= DUTY_RST;
      pkt_ok_reg <= 1'b0;
    end else begin
      pkt_ok_reg <= 1'b0;
      if (brk_ok && pend_reg && b2b_in_window) begin
        duty_reg <= sel_val_reg;
        pkt_ok_reg <= 1'b1;
      end
    end
  end

  // Dimmer output at a fixed rate
  dsr_pwm #(
    .PERIOD_CYC(PWM_PERIOD_CYC)
  ) u_pwm (
    .core_clk_i(core_clk_i),
    .reset_i(reset_i),
    .duty_i(duty_reg),
    .pwm_o(pwm_o)
  );

  assign slot_rd_data_o = slot_rd_data_reg;
  assign duty_o = duty_reg;
  assign pkt_ok_o = pkt_ok_reg;

  default clocking cb @(posedge core_clk_i);
  endclocking
  default disable iff (reset_i);

  sequence s_framing_cut;
    (state_reg == ST_DATA && slot_evt.frame_err) ##1 (state_reg == ST_IDLE);
  endsequence

  sequence s_bad_code;
    (state_reg == ST_DATA && slot_evt.valid && code_bad) ##1 (state_reg == ST_SKIP);
  endsequence

  chk_break_min_len: assert property (
    $rose(state_reg == ST_MARK) |-> $past(low_len) >= BREAK_MIN_T)
    else $error("Break shorter than minimum was accepted");
  chk_mab_min_len: assert property (
    $rose(state_reg == ST_DATA) |-> $past(high_len) >= MARK_MIN_T)
    else $error("Mark after break shorter than minimum was accepted");
  chk_store_gated: assert property (
    wr_en |-> (state_reg == ST_DATA) && $past(state_reg != ST_IDLE))
    else $error("Slot stored without a validated reset");
  chk_frame_stops: assert property (
    s_framing_cut |-> !wr_en [*2])
    else $error("Storing continued after a framing error");
  chk_slot_limit: assert property (
    (state_reg == ST_DATA) |-> slot_idx_reg <= LAST_SLOT)
    else $error("Slot beyond the last position was stored");
  chk_bad_code_skip: assert property (
    s_bad_code |-> !wr_en && $stable(duty_reg))
    else $error("Non-null start code packet was not ignored");
  chk_addr_capture: assert property (
    (wr_en && slot_idx_reg == slot_addr_i && !brk_ok && !stale)
      |=> pend_reg && sel_val_reg == $past(slot_evt.data))
    else $error("Addressed slot was not captured");
  chk_duty_cause: assert property (
    (duty_reg != $past(duty_reg)) |-> $past(brk_ok && pend_reg && b2b_in_window))
    else $error("Duty changed without a complete valid packet");
  chk_stale_drop: assert property (
    (stale && !brk_ok) |=> !pend_reg)
    else $error("Overlong packet was not discarded");
  chk_fall_stamp: assert property (
    fall_edge |=> fall_stamp_reg == $past(now_reg))
    else $error("Falling edge time not recorded");
endmodule : dsr_receiver

//--- dsr_pkg.sv
package dsr_pkg;
  // Clock and serial timing
  localparam int CLK_NS = 40;
  localparam int BIT_NS = 4000;
  localparam int BIT_CYC = BIT_NS / CLK_NS;
  localparam int HALF_BIT_CYC = BIT_CYC / 2;
  localparam int DATA_BITS = 8;
  localparam int STOP_BITS = 2;
  localparam int CNT_W = 16;

  // Reset sequence limits, least times rounded up
  localparam int BREAK_MIN_NS = 88000;
  localparam int BREAK_MIN_CYC = (BREAK_MIN_NS + CLK_NS - 1) / CLK_NS;
  localparam int MARK_MIN_NS = 8000;
  localparam int MARK_MIN_CYC = (MARK_MIN_NS + CLK_NS - 1) / CLK_NS;

  // Break to break window, longest time rounded down
  localparam int PKT_MIN_NS = 1196000;
  localparam int PKT_MIN_CYC = (PKT_MIN_NS + CLK_NS - 1) / CLK_NS;
  localparam int PKT_MAX_NS = 1250000000;
  localparam int PKT_MAX_CYC = PKT_MAX_NS / CLK_NS;

  // Dimmer output
  localparam int PWM_HZ = 120;
  localparam int PWM_PERIOD_CYC = 1000000000 / (CLK_NS * PWM_HZ);
  localparam int SLOT_FULL = 255;

  // Packet layout
  localparam int SLOT_MAX = 512;
  localparam int SLOT_COUNT = SLOT_MAX + 1;
  localparam int IDX_W = 10;
  localparam int TIME_W = 32;

  typedef logic [7:0] dsr_slot_t;
  typedef logic [IDX_W-1:0] dsr_idx_t;
  typedef logic [TIME_W-1:0] dsr_time_t;

  localparam dsr_slot_t NULL_START = 8'h00;
  localparam dsr_slot_t SLOT_RST = 8'h00;
  localparam dsr_slot_t DUTY_RST = 8'h00;

  // One received slot, or a framing error, as a single-cycle event
  typedef struct packed {
    logic valid;
    logic frame_err;
    dsr_slot_t data;
  } dsr_slot_evt_t;
endpackage : dsr_pkg

//--- dsr_slot_rx.sv
`timescale 1ns/1ns
module dsr_slot_rx (
  input wire logic core_clk_i,
  input wire logic reset_i,
  input wire logic line_i,
  output dsr_pkg::dsr_slot_evt_t evt_o
);
  import dsr_pkg::*;

  typedef enum logic [2:0] {RX_HUNT, RX_START, RX_DATA, RX_STOP, RX_WAIT_HIGH} dsr_rx_state_t;

  localparam logic [CNT_W-1:0] BIT_LOAD = CNT_W'(BIT_CYC - 1);
  localparam logic [CNT_W-1:0] HALF_LOAD = CNT_W'(HALF_BIT_CYC - 1);
  localparam logic [3:0] LAST_DATA = 4'(DATA_BITS - 1);
  localparam logic [3:0] LAST_STOP = 4'(STOP_BITS - 1);

  dsr_rx_state_t state_reg;
  logic [CNT_W-1:0] cnt_reg;
  logic [3:0] bit_reg;
  dsr_slot_t shift_reg;
  dsr_slot_evt_t evt_reg;

  // Mid-bit sampling leaves half a bit of margin over a whole slot,
  // well beyond the 2 percent rate spread a transmitter may have
  always_ff @(posedge core_clk_i) begin
    if (reset_i) begin
      state_reg <= RX_WAIT_HIGH;
      cnt_reg <= '0;
      bit_reg <= '0;
      shift_reg <= '0;
      evt_reg <= '0;
    end else begin
      evt_reg <= '0;
      unique case (state_reg)
        RX_HUNT: begin
          if (!line_i) begin
            state_reg <= RX_START;
            cnt_reg <= HALF_LOAD;
          end
        end
        RX_START: begin
          if (cnt_reg != '0) begin
            cnt_reg <= cnt_reg - 1'b1;
          end else if (!line_i) begin
            state_reg <= RX_DATA;
            cnt_reg <= BIT_LOAD;
            bit_reg <= '0;
          end else begin
            state_reg <= RX_HUNT; // Glitch, not a start bit
          end
        end
        RX_DATA: begin
          if (cnt_reg != '0) begin
            cnt_reg <= cnt_reg - 1'b1;
          end else begin
            shift_reg <= {line_i, shift_reg[7:1]}; // LSB arrives first
            cnt_reg <= BIT_LOAD;
            if (bit_reg == LAST_DATA) begin
              state_reg <= RX_STOP;
              bit_reg <= '0;
            end else begin
              bit_reg <= bit_reg + 1'b1;
            end
          end
        end
        RX_STOP: begin
          if (cnt_reg != '0) begin
            cnt_reg <= cnt_reg - 1'b1;
          end else if (!line_i) begin
            evt_reg.frame_err <= 1'b1; // Low stop bit, e.g. a break
            state_reg <= RX_WAIT_HIGH;
          end else if (bit_reg == LAST_STOP) begin
            evt_reg.valid <= 1'b1; // Both stop bits high
            evt_reg.data <= shift_reg;
            state_reg <= RX_HUNT;
          end else begin
            bit_reg <= bit_reg + 1'b1;
            cnt_reg <= BIT_LOAD;
          end
        end
        RX_WAIT_HIGH: begin
          if (line_i) begin
            state_reg <= RX_HUNT;
          end
        end
      endcase
    end
  end

  assign evt_o = evt_reg;
endmodule : dsr_slot_rx

//--- dsr_pwm.sv
`timescale 1ns/1ns
module dsr_pwm #(
  parameter int PERIOD_CYC = dsr_pkg::PWM_PERIOD_CYC
) (
  input wire logic core_clk_i,
  input wire logic reset_i,
  input dsr_pkg::dsr_slot_t duty_i,
  output logic pwm_o
);
  import dsr_pkg::*;

  localparam int CW = $clog2(PERIOD_CYC);
  localparam logic [CW-1:0] LAST = CW'(PERIOD_CYC - 1);

  logic [CW-1:0] cnt_reg;
  dsr_slot_t duty_cur_reg;
  logic pwm_reg;
  logic [31:0] thr;

  // High time scales linearly: 255 is the whole period, 0 is none
  assign thr = (32'(duty_cur_reg) * 32'(PERIOD_CYC)) / 32'(SLOT_FULL);

  // Period counter; new duty taken only at a period boundary to avoid runt pulses
  always_ff @(posedge core_clk_i) begin
    if (reset_i) begin
      cnt_reg <= '0;
      duty_cur_reg <= DUTY_RST;
    end else if (cnt_reg == LAST) begin
      cnt_reg <= '0;
      duty_cur_reg <= duty_i;
    end else begin
      cnt_reg <= cnt_reg + 1'b1;
    end
  end

  // High first, then low, within each fixed period
  always_ff @(posedge core_clk_i) begin
    if (reset_i) begin
      pwm_reg <= 1'b0;
    end else begin
      pwm_reg <= (32'(cnt_reg) < thr);
    end
  end

  assign pwm_o = pwm_reg;

  chk_pwm_full_on: assert property (@(posedge core_clk_i) disable iff (reset_i)
    (duty_cur_reg == 8'hff) |=> pwm_reg) else $error("Full duty did not hold output high");
  chk_pwm_full_off: assert property (@(posedge core_clk_i) disable iff (reset_i)
    (duty_cur_reg == 8'h00) |=> !pwm_reg) else $error("Zero duty did not hold output low");
  chk_pwm_period_start: assert property (@(posedge core_clk_i) disable iff (reset_i)
    (cnt_reg == '0 && duty_cur_reg != 8'h00) |=> pwm_reg) else $error("Period did not start high");
endmodule : dsr_pwm

//--- dsr_tx_model.sv
`timescale 1ns/1ns
module dsr_tx_model (
  input wire logic core_clk_i,
  output logic line_o
);
  import dsr_pkg::*;
  // Line rests at mark outside frames
  initial line_o = 1'b1;

  // Hold one level for a number of clocks, changed just after an edge
  task automatic hold(input logic lvl, input int cyc);
    @(posedge core_clk_i);
    line_o <= lvl;
    repeat (cyc - 1) @(posedge core_clk_i);
  endtask : hold

  // Space then mark open every packet
  task automatic tx_break(input int brk, input int mark);
    hold(1'b0, brk);
    hold(1'b1, mark);
  endtask : tx_break

  // One slot; a bad slot drives its stop bits low to force a framing error
  task automatic tx_slot(input dsr_slot_t v, input int bitc, input bit bad);
    hold(1'b0, bitc);
    for (int i = 0; i < DATA_BITS; i++) begin
      hold(v[i], bitc);
    end
    hold(bad ? 1'b0 : 1'b1, STOP_BITS * bitc);
    hold(1'b1, 1 + $urandom_range(20)); // Random mark between slots
  endtask : tx_slot

  // Reset sequence, start code, then data slots
  task automatic tx_pkt(input dsr_slot_t d[$], input int brk, input int mark,
                        input int bitc, input int bad_at);
    tx_break(brk, mark);
    foreach (d[i]) tx_slot(d[i], bitc, i == bad_at);
  endtask : tx_pkt
endmodule : dsr_tx_model

//--- tb_top.sv
`timescale 1ns/1ns
module tb_top;
  import dsr_pkg::*;
  localparam int T_PKT_MIN = 300;
  localparam int T_PKT_MAX = 12000;
  localparam int T_PWM = 510;
  logic core_clk_i = 1'b0;
  logic reset_i = 1'b1;
  logic line;
  dsr_idx_t slot_addr = '0;
  dsr_idx_t rd_idx = '0;
  dsr_slot_t rd_data;
  dsr_slot_t duty;
  logic pkt_ok;
  logic pwm;
  int errors = 0;
  int total_checks = 0;
  int cur_duty = 0;
  int hi;
  dsr_slot_t exp_duty_q[$];
  dsr_slot_t exp_rd_q[$];
  dsr_slot_t buf_exp[0:15] = '{default: 8'h00};
  logic rd_req = 1'b0;
  logic rd_req_d = 1'b0;
  bit mon_en = 1'b1;
  bit pend = 1'b0;
  dsr_slot_t pend_val;

  // Clock at 25 MHz
  initial forever #20 core_clk_i = ~core_clk_i;

  dsr_tx_model u_tx (
    .core_clk_i(core_clk_i),
    .line_o(line)
  );

  dsr_receiver #(
    .PKT_MIN_CYC(T_PKT_MIN),
    .PKT_MAX_CYC(T_PKT_MAX),
    .PWM_PERIOD_CYC(T_PWM)
  ) i_dut (
    .core_clk_i(core_clk_i),
    .reset_i(reset_i),
    .line_receive_input_i(line),
    .slot_addr_i(slot_addr),
    .slot_rd_idx_i(rd_idx),
    .slot_rd_data_o(rd_data),
    .duty_o(duty),
    .pkt_ok_o(pkt_ok),
    .pwm_o(pwm)
  );

  // Compare one value and count it
  task automatic check(input string what, input dsr_slot_t exp, input dsr_slot_t got);
    total_checks++;
    if (got !== exp) begin
      errors++;
      $display("[ERR] %s expected %h seen %h", what, exp, got);
    end
  endtask : check

  // Print counts and verdict, then stop
  task automatic wrap_up();
    $display("checks %0d errors %0d", total_checks, errors);
    if (errors == 0 && total_checks > 0) begin
      $display("ALL TESTS PASSED");
    end else begin
      $display("TESTS FAILED");
    end
    $finish;
  endtask : wrap_up

  // Result watcher: read data one cycle after a request, duty on each update pulse
  always @(posedge core_clk_i) begin
    rd_req_d <= rd_req;
    if (rd_req_d) check("slot_rd_data_o", exp_rd_q.pop_front(), rd_data);
    if (!reset_i && mon_en && pkt_ok === 1'b1) begin
      if (exp_duty_q.size() == 0) begin
        check("pkt_ok_o", 8'h00, 8'h01);
      end else begin
        check("duty_o", exp_duty_q.pop_front(), duty);
      end
    end
  end

  // Read one buffer entry and note what it should hold
  task automatic rd(input int idx, input dsr_slot_t exp);
    @(posedge core_clk_i);
    rd_idx <= dsr_idx_t'(idx);
    rd_req <= 1'b1;
    exp_rd_q.push_back(exp);
    @(posedge core_clk_i);
    rd_req <= 1'b0;
  endtask : rd

  // Send one packet of four slots, then read the buffer back
  task automatic run_pkt(input string name, input dsr_slot_t sc, input int addr,
                         input int brk, input int mark, input int bitc,
                         input int bad_at, input bit upd);
    dsr_slot_t d[$];
    bit good;
    d.push_back(sc);
    // A cut packet selects a full-scale slot ahead of its error
    for (int i = 1; i < 4; i++) begin
      d.push_back((i == addr && bad_at > addr) ? 8'hff : dsr_slot_t'($urandom));
    end
    @(posedge core_clk_i);
    slot_addr <= dsr_idx_t'(addr);
    if (pend) begin
      exp_duty_q.push_back(pend_val);
      cur_duty = int'(pend_val);
    end
    pend = 1'b0;
    u_tx.tx_pkt(d, brk, mark, bitc, bad_at);
    good = (sc == NULL_START) && brk >= BREAK_MIN_CYC && mark >= MARK_MIN_CYC;
    foreach (d[i]) if (good && (bad_at < 0 || i < bad_at)) buf_exp[i] = d[i];
    pend = good && upd;
    pend_val = d[addr];
    for (int i = 0; i < 5; i++) rd(i, buf_exp[i]);
    $display("test %s done", name);
  endtask : run_pkt

  // Cut a hang short
  initial begin
    repeat (95000) @(posedge core_clk_i);
    errors++;
    $display("[ERR] run_length expected end seen limit");
    wrap_up();
  end

  // Main sequence
  initial begin
    void'($urandom(32'hcb1c));
    repeat (16) @(posedge core_clk_i);
    reset_i <= 1'b0;
    run_pkt("ignored_start", 8'h55, 1, 2300, 250, 100, -1, 1'b0);
    run_pkt("null_start", 8'h00, 3, 2300, 250, 100, -1, 1'b1);
    run_pkt("frame_err", 8'h00, 1, 2300, 250, 100, 2, 1'b0);
    // A packet cut by a framing error may or may not update duty
    mon_en = 1'b0;
    run_pkt("second_ignored", 8'haa, 2, 2300, 250, 100, -1, 1'b0);
    mon_en = 1'b1;
    run_pkt("short_break", 8'h00, 2, 2000, 250, 100, -1, 1'b0);
    run_pkt("short_mark", 8'h00, 2, 2300, 150, 100, -1, 1'b0);
    run_pkt("fast_bits", 8'h00, 0, 2300, 250, 98, -1, 1'b1);
    run_pkt("slow_bits", 8'h00, 3, 2300, 250, 102, -1, 1'b1);
    run_pkt("long_gap", 8'h00, 1, 2300, 250, 100, -1, 1'b0);
    // Duty from the last good packet drives the dimmer output
    repeat (600) @(posedge core_clk_i);
    hi = 0;
    for (int i = 0; i < T_PWM; i++) begin
      @(posedge core_clk_i);
      if (pwm === 1'b1) hi++;
    end
    total_checks++;
    if (hi < 2 * cur_duty - 1 || hi > 2 * cur_duty + 1) begin
      errors++;
      $display("[ERR] pwm_o high cycles expected %0d seen %0d", 2 * cur_duty, hi);
    end
    $display("test pwm_duty done");
    // Break after an overlong gap must not update duty
    repeat (T_PKT_MAX) @(posedge core_clk_i);
    u_tx.tx_break(2300, 250);
    repeat (20) @(posedge core_clk_i);
    rd(600, 8'h00);
    repeat (4) @(posedge core_clk_i);
    check("pending_updates", 8'h00, 8'(exp_duty_q.size()));
    $display("test long_gap_end done");
    wrap_up();
  end
endmodule : tb_top
